// >>> common/sbsr_consts.svh
// constants for the status byte and service request block
`ifndef SBSR_CONSTS_SVH
`define SBSR_CONSTS_SVH

// ----------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------
`define SBSR_BIT_MSB 0
`define SBSR_BIT_SPARE 1
`define SBSR_BIT_EAV 2
`define SBSR_BIT_QSB 3
`define SBSR_BIT_MAV 4
`define SBSR_BIT_ESB 5
`define SBSR_BIT_RQS 6
`define SBSR_BIT_OSB 7

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SBSR_BYTE_W 8
`define SBSR_QUES_W 16
`define SBSR_BYTE_ZERO 8'h00
`define SBSR_QUES_ZERO 16'h0000
// summary bits that take part in the enable mask (b0, b2..b5, b7)
`define SBSR_SUMMARY_MASK 8'hbd

`endif

// >>> common/sbsr_pkg.sv
// types shared by the status byte and service request modules
package sbsr_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic [7:0] status_byte_t;

	// query responder: one-hot states
	typedef enum logic [3:0] {
		RESP_IDLE = 4'b0001,
		RESP_STB = 4'b0010,
		RESP_POLL = 4'b0100,
		RESP_SRE = 4'b1000
	} resp_state_e;

endpackage

// >>> common/sbsr_edge_if.sv
// carrier between the status byte core and its edge detector
`timescale 1ns/10ps
interface sbsr_edge_if;
	logic [7:0] enabled;
	logic [7:0] rise;
	logic any_rise;
	logic clear;

	modport core (
		output enabled,
		output clear,
		input rise,
		input any_rise
	);
	modport detect (
		input enabled,
		input clear,
		output rise,
		output any_rise
	);
endinterface

// >>> src/sbsr_edge_detect.sv
// rising-edge detector for enabled status summary bits
`timescale 1ns/10ps
`include "sbsr_consts.svh"
module sbsr_edge_detect (
	input wire logic i_mclk, // system clock
	input wire logic i_sys_rst, // synchronous reset, active high
	sbsr_edge_if.detect edge_port // enabled summaries in, edges out
);

	// ----------------------------------------------------------------
	// history of the enabled summary vector
	// ----------------------------------------------------------------
	logic [7:0] prev_q;
	logic [7:0] prev_d;
	logic [7:0] rise_w;

	// on a clear the history is forced low so a summary that stays high
	// afterwards is seen as a fresh edge and can request service again
	assign prev_d = edge_port.clear ? `SBSR_BYTE_ZERO : edge_port.enabled;
	assign rise_w = edge_port.enabled & ~prev_q;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			prev_q <= `SBSR_BYTE_ZERO;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign edge_port.rise = rise_w;
	assign edge_port.any_rise = |rise_w;

endmodule

// >>> src/status_byte_service_request.sv
// status byte, service request enable mask and srq generation
`timescale 1ns/10ps
`include "sbsr_consts.svh"

module status_byte_service_request #(
	parameter int QUES_W = `SBSR_QUES_W // questionable register width
) (
	input wire logic i_mclk, // 25 mhz system clock
	input wire logic i_sys_rst, // synchronous reset, active high
	input wire logic i_meas_summary, // measurement summary (b0)
	input wire logic i_errq_empty, // error queue holds no message
	input wire logic [QUES_W-1:0] i_ques_event, // questionable event register
	input wire logic [QUES_W-1:0] i_ques_enable, // questionable enable register
	input wire logic i_outq_empty, // output queue holds no message
	input wire logic i_std_event_summary, // standard event summary (b5)
	input wire logic i_oper_summary, // operation summary (b7)
	input wire logic i_clear_status, // clear-status command, pulse
	input wire logic i_sre_write, // enable mask write command, pulse
	input wire logic [7:0] i_sre_wdata, // value of the mask write
	input wire logic i_sre_query, // enable mask query, pulse
	input wire logic i_stb_query, // status byte query, pulse
	input wire logic i_serial_poll, // serial poll byte request, pulse
	output logic o_srq, // service request line, active high
	output logic [7:0] o_status_live, // live byte with master summary in b6
	output logic [7:0] o_resp_data, // answer byte for the last request
	output logic o_resp_valid, // answer strobe, one cycle
	output logic [7:0] o_service_mask, // current enable mask
	output logic o_mss // master summary status
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	sbsr_edge_if edge_port ();

	sbsr_pkg::status_byte_t summary_w;
	sbsr_pkg::status_byte_t enabled_w;
	sbsr_pkg::status_byte_t stb_mss_w;
	sbsr_pkg::status_byte_t stb_rqs_w;
	sbsr_pkg::status_byte_t sre_next_w;
	sbsr_pkg::resp_state_e state_q;
	sbsr_pkg::resp_state_e state_d;

	logic [7:0] sre_q;
	logic [7:0] sre_d;
	logic rqs_q;
	logic rqs_d;
	logic srq_q;
	logic mss_w;
	logic ques_summary_w;
	logic mav_w;
	logic eav_w;
	logic rqs_set_w;
	logic rqs_clr_w;
	logic mav_hold_q;
	logic mav_hold_d;
	logic [7:0] resp_data_q;
	logic [7:0] resp_data_d;
	logic resp_valid_q;
	logic resp_valid_d;
	logic [7:0] live_q;
	logic mss_q;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// places b6 into a byte built from the summary bits
	function automatic logic [7:0] with_b6(input logic [7:0] sum, input logic b6);
		logic [7:0] r;
		r = sum & `SBSR_SUMMARY_MASK;
		r[`SBSR_BIT_RQS] = b6;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// summary messages
	// ----------------------------------------------------------------
	// the questionable summary is formed here from its event and enable
	// registers, mav and eav from the queue-empty flags; the others arrive already formed
	assign ques_summary_w = |(i_ques_event & i_ques_enable);
	assign mav_w = ~i_outq_empty;
	assign eav_w = ~i_errq_empty;

	// a clear cannot reach into the output queue, so mav is shown only
	// as the queue reports it; the hold flag records that a clear came
	assign mav_hold_d = i_clear_status ? 1'b1 : (i_outq_empty ? 1'b0 : mav_hold_q);

	always_comb begin
		summary_w = `SBSR_BYTE_ZERO;
		summary_w[`SBSR_BIT_MSB] = i_meas_summary;
		summary_w[`SBSR_BIT_EAV] = eav_w;
		summary_w[`SBSR_BIT_QSB] = ques_summary_w;
		summary_w[`SBSR_BIT_MAV] = mav_w;
		summary_w[`SBSR_BIT_ESB] = i_std_event_summary;
		summary_w[`SBSR_BIT_OSB] = i_oper_summary;
	end

	// ----------------------------------------------------------------
	// enable mask and master summary
	// ----------------------------------------------------------------
	// b6 of the mask has no summary behind it and is kept at zero
	assign sre_next_w = i_sre_wdata & `SBSR_SUMMARY_MASK;
	assign sre_d = i_sre_write ? sre_next_w : sre_q;
	assign enabled_w = summary_w & sre_q;
	assign mss_w = |enabled_w;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sre_q <= `SBSR_BYTE_ZERO;
		end else begin
			sre_q <= sre_d;
		end
	end

	// ----------------------------------------------------------------
	// request for service
	// ----------------------------------------------------------------
	assign edge_port.enabled = enabled_w;
	assign edge_port.clear = i_serial_poll | i_clear_status;

	sbsr_edge_detect u_edge (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.edge_port(edge_port)
	);

	assign rqs_set_w = edge_port.any_rise;
	assign rqs_clr_w = i_serial_poll | i_clear_status;
	// a new edge in the cycle of the poll wins, so no request is lost
	assign rqs_d = rqs_set_w ? 1'b1 : (rqs_clr_w ? 1'b0 : rqs_q);

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rqs_q <= 1'b0;
			srq_q <= 1'b0;
			mav_hold_q <= 1'b0;
		end else begin
			rqs_q <= rqs_d;
			srq_q <= rqs_d;
			mav_hold_q <= mav_hold_d;
		end
	end

	// ----------------------------------------------------------------
	// byte images
	// ----------------------------------------------------------------
	// the query image carries the master summary in b6
	assign stb_mss_w = with_b6(summary_w, mss_w);
	// the poll image carries the request flag as it stood before the poll
	assign stb_rqs_w = with_b6(summary_w, rqs_q);

	// ----------------------------------------------------------------
	// query responder
	// ----------------------------------------------------------------
	// a serial poll takes priority over a status query, which takes
	// priority over a mask query; only one answer leaves per cycle
	always_comb begin
		state_d = sbsr_pkg::RESP_IDLE;
		if (i_serial_poll) begin
			state_d = sbsr_pkg::RESP_POLL;
		end else if (i_stb_query) begin
			state_d = sbsr_pkg::RESP_STB;
		end else if (i_sre_query) begin
			state_d = sbsr_pkg::RESP_SRE;
		end
	end

	always_comb begin
		resp_data_d = resp_data_q;
		resp_valid_d = 1'b0;
		case (state_d)
			sbsr_pkg::RESP_IDLE: begin
				resp_valid_d = 1'b0;
			end
			sbsr_pkg::RESP_POLL: begin
				resp_data_d = stb_rqs_w;
				resp_valid_d = 1'b1;
			end
			sbsr_pkg::RESP_STB: begin
				resp_data_d = stb_mss_w;
				resp_valid_d = 1'b1;
			end
			sbsr_pkg::RESP_SRE: begin
				resp_data_d = sre_q;
				resp_valid_d = 1'b1;
			end
			default: begin
				resp_valid_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state_q <= sbsr_pkg::RESP_IDLE;
			resp_data_q <= `SBSR_BYTE_ZERO;
			resp_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			resp_data_q <= resp_data_d;
			resp_valid_q <= resp_valid_d;
		end
	end

	// ----------------------------------------------------------------
	// live outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			live_q <= `SBSR_BYTE_ZERO;
			mss_q <= 1'b0;
		end else begin
			live_q <= stb_mss_w;
			mss_q <= mss_w;
		end
	end

	assign o_srq = srq_q;
	assign o_status_live = live_q;
	assign o_resp_data = resp_data_q;
	assign o_resp_valid = resp_valid_q;
	assign o_service_mask = sre_q;
	assign o_mss = mss_q;

endmodule

// >>> sim/sbsr_properties.sv
// concurrent checks on the status byte and service request ports
`timescale 1ns/10ps
module sbsr_properties #(
	parameter int QUES_W = 16 // questionable width
) (
	input wire logic i_mclk, // in
	input wire logic i_sys_rst, // in
	input wire logic i_meas_summary, // in
	input wire logic i_errq_empty, // in
	input wire logic [QUES_W-1:0] i_ques_event, // in
	input wire logic [QUES_W-1:0] i_ques_enable, // in
	input wire logic i_outq_empty, // in
	input wire logic i_std_event_summary, // in
	input wire logic i_oper_summary, // in
	input wire logic i_clear_status, // in
	input wire logic i_sre_write, // in
	input wire logic [7:0] i_sre_wdata, // in
	input wire logic i_sre_query, // in
	input wire logic i_stb_query, // in
	input wire logic i_serial_poll, // in
	input wire logic o_srq, // out
	input wire logic [7:0] o_status_live, // out
	input wire logic [7:0] o_resp_data, // out
	input wire logic o_resp_valid, // out
	input wire logic [7:0] o_service_mask, // out
	input wire logic o_mss // out
);
	// ----------------------------------------------------------------
	// expected summaries and edge history
	// ----------------------------------------------------------------
	logic [7:0] sum_v;
	logic [7:0] en_v;
	logic [7:0] hist_q;
	logic rise_w;
	assign sum_v = {i_oper_summary, 1'h0, i_std_event_summary, ~i_outq_empty,
		|(i_ques_event & i_ques_enable), ~i_errq_empty, 1'h0, i_meas_summary};
	assign en_v = sum_v & o_service_mask;
	assign rise_w = |(en_v & ~hist_q);
	// history is zeroed like the design's, or a re-request would look spurious
	always_ff @(posedge i_mclk) begin
		hist_q <= (i_sys_rst | i_serial_poll | i_clear_status) ? 8'h00 : en_v;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	a_live_follow: assert property (
		!$past(i_sys_rst) |-> o_status_live == ($past(sum_v) | {1'h0, o_mss, 6'h00}))
		else $error("status byte does not follow summaries");
	a_mss_or: assert property (
		!$past(i_sys_rst) |-> o_mss == |($past(en_v))) else $error("master summary wrong");
	a_mask_write: assert property (
		i_sre_write |=> o_service_mask == ($past(i_sre_wdata) & 8'hbd))
		else $error("mask write not stored");
	a_mask_hold: assert property (
		!i_sre_write |=> $stable(o_service_mask)) else $error("mask changed unasked");
	a_stb_answer: assert property (
		i_stb_query && !i_serial_poll |=> o_resp_valid && o_resp_data == o_status_live)
		else $error("status query answer wrong");
	a_sre_answer: assert property (
		i_sre_query && !i_stb_query && !i_serial_poll |=> o_resp_valid
		&& o_resp_data == $past(o_service_mask)) else $error("mask query answer wrong");
	a_poll_answer: assert property (
		i_serial_poll |=> o_resp_valid && o_resp_data ==
		{o_status_live[7], $past(o_srq), o_status_live[5:0]}) else $error("poll byte wrong");
	a_poll_clears: assert property (
		(i_serial_poll || i_clear_status) && !rise_w |=> !o_srq)
		else $error("request not cleared");
	a_srq_rise: assert property (
		rise_w && !i_clear_status |=> o_srq) else $error("enabled rise gave no request");
	a_srq_hold: assert property (
		o_srq && !i_serial_poll && !i_clear_status |=> o_srq) else $error("request dropped");
endmodule

bind status_byte_service_request sbsr_properties #(.QUES_W(QUES_W)) u_props (
	.i_mclk, .i_sys_rst, .i_meas_summary, .i_errq_empty, .i_ques_event,
	.i_ques_enable, .i_outq_empty, .i_std_event_summary, .i_oper_summary,
	.i_clear_status, .i_sre_write, .i_sre_wdata, .i_sre_query, .i_stb_query,
	.i_serial_poll, .o_srq, .o_status_live, .o_resp_data, .o_resp_valid,
	.o_service_mask, .o_mss
);

// >>> sim/sbsr_host_model.sv
// bus controller model issuing status queries, mask queries and polls
`timescale 1ns/10ps
module sbsr_host_model (
	input wire logic i_mclk, // clock
	input wire logic i_resp_valid, // answer strobe
	input wire logic [7:0] i_resp_data, // answer byte
	output logic o_stb_query, // status query
	output logic o_sre_query, // mask query
	output logic o_serial_poll // serial poll
);
	// ----------------------------------------------------------------
	// requests
	// ----------------------------------------------------------------
	initial begin
		{o_stb_query, o_sre_query, o_serial_poll} = 3'h0;
	end
	// kind 0 status, 1 mask, 2 poll; the strobe lasts one cycle, as a pulse
	task automatic ask(input int kind, output logic [7:0] data, output logic ok);
		@(negedge i_mclk);
		o_stb_query = (kind == 0);
		o_sre_query = (kind == 1);
		o_serial_poll = (kind == 2);
		@(negedge i_mclk);
		{o_stb_query, o_sre_query, o_serial_poll} = 3'h0;
		ok = (i_resp_valid === 1'h1);
		data = i_resp_data;
	endtask
endmodule

// >>> sim/tb_status_byte_service_request.sv
// self-checking bench for the status byte and service request block
`timescale 1ns/10ps
module tb_status_byte_service_request;
	logic i_mclk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic i_meas_summary = 1'h0;
	logic i_errq_empty = 1'h1;
	logic [3:0] i_ques_event = 4'h0;
	logic [3:0] i_ques_enable = 4'h0;
	logic i_outq_empty = 1'h1;
	logic i_std_event_summary = 1'h0;
	logic i_oper_summary = 1'h0;
	logic i_clear_status = 1'h0;
	logic i_sre_write = 1'h0;
	logic [7:0] i_sre_wdata = 8'h00;
	logic i_sre_query, i_stb_query, i_serial_poll, o_srq, o_resp_valid, o_mss, ok;
	logic [7:0] o_status_live, o_resp_data, o_service_mask, rd;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	// mask, summaries, questionable event and enable, expected byte
	logic [31:0] rows [9] = '{32'h00bd11bd, 32'hff010041, 32'h20200060, 32'h08005a00,
		32'h08006248, 32'h10100050, 32'h04040044, 32'h808100c1, 32'h00000000};
	status_byte_service_request #(.QUES_W(4)) u_dut (
		.i_mclk, .i_sys_rst, .i_meas_summary, .i_errq_empty, .i_ques_event,
		.i_ques_enable, .i_outq_empty, .i_std_event_summary, .i_oper_summary,
		.i_clear_status, .i_sre_write, .i_sre_wdata, .i_sre_query, .i_stb_query,
		.i_serial_poll, .o_srq, .o_status_live, .o_resp_data, .o_resp_valid,
		.o_service_mask, .o_mss
	);
	sbsr_host_model u_host (.i_mclk, .i_resp_valid(o_resp_valid), .i_resp_data(o_resp_data),
		.o_stb_query(i_stb_query), .o_sre_query(i_sre_query), .o_serial_poll(i_serial_poll));
	always #20 i_mclk = ~i_mclk;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask
	task automatic pulse_write(input logic [7:0] d);
		@(negedge i_mclk);
		i_sre_write = 1'h1;
		i_sre_wdata = d;
		@(negedge i_mclk);
		i_sre_write = 1'h0;
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			complete_run;
		end
	end
	initial begin
		repeat (10) @(negedge i_mclk);
		i_sys_rst = 1'h0;
		for (int r = 0; r < 9; r++) begin
			pulse_write(rows[r][31:24]);
			{i_oper_summary, i_std_event_summary, i_meas_summary} =
				{rows[r][23], rows[r][21], rows[r][16]};
			{i_outq_empty, i_errq_empty} = ~{rows[r][20], rows[r][18]};
			{i_ques_event, i_ques_enable} = rows[r][15:8];
			@(negedge i_mclk);
			chk(o_status_live, rows[r][7:0], "live byte");
			u_host.ask(0, rd, ok);
			chk(rd, rows[r][7:0], "status query");
			u_host.ask(1, rd, ok);
			chk(rd, rows[r][31:24] & 8'hbd, "mask query");
			chk({7'h00, ok}, 8'h01, "no answer strobe");
			$display("row %0d done", r);
		end
		pulse_write(8'h20);
		i_std_event_summary = 1'h1;
		repeat (2) @(negedge i_mclk);
		chk({7'h00, o_srq}, 8'h01, "no request");
		u_host.ask(0, rd, ok);
		chk({6'h00, rd[6], o_srq}, 8'h03, "query touched request");
		u_host.ask(2, rd, ok);
		chk(rd, 8'h60, "poll byte");
		chk({6'h00, o_srq, o_mss}, 8'h01, "poll cleared too much");
		@(negedge i_mclk);
		chk({7'h00, o_srq}, 8'h01, "no re-request");
		i_clear_status = 1'h1;
		@(negedge i_mclk);
		i_clear_status = 1'h0;
		chk({7'h00, o_srq}, 8'h00, "clear kept request");
		i_std_event_summary = 1'h0;
		@(negedge i_mclk);
		chk(o_status_live, 8'h00, "summary drop");
		$display("request test done");
		// a mid-run reset stands in for a power cycle
		pulse_write(8'hff);
		i_sys_rst = 1'h1;
		@(negedge i_mclk);
		chk(o_service_mask | o_status_live | o_srq, 8'h00, "reset values");
		i_sys_rst = 1'h0;
		$display("reset test done");
		complete_run;
	end
endmodule
